/* logic/ibdw_pkg.sv */
// Purpose: Shared constants and types for the image buffer DMA writer
// Assumes: 32-bit register port, byte addresses into host memory
// Notes: Offsets are word-aligned byte addresses
package ibdw_pkg;
    localparam int unsigned AW = 32;
    localparam int unsigned DW = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LINE_PAYLOAD = 8'h04;
    localparam logic [7:0] OFS_LINE_STRIDE = 8'h08;
    localparam logic [7:0] OFS_GROUP_HEIGHT = 8'h0C;
    localparam logic [7:0] OFS_GROUP_STRIDE = 8'h10;
    localparam logic [7:0] OFS_BUF_START = 8'h14;
    localparam logic [7:0] OFS_BUF_LENGTH = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_WIN_SELECT = 8'h20;
    localparam logic [7:0] OFS_WIN_BUFFERS = 8'h24;
    localparam logic [7:0] OFS_WIN_UNITS = 8'h28;
    localparam logic [7:0] OFS_WIN_BYTES = 8'h2C;
    localparam logic [7:0] OFS_WIN_CYCLES = 8'h30;
    localparam logic [7:0] OFS_AVG_FRAME_RATE = 8'h34;
    localparam logic [7:0] OFS_AVG_LINE_RATE = 8'h38;
    localparam logic [7:0] OFS_AVG_BYTE_RATE = 8'h3C;
    // Control bit positions
    localparam int unsigned CTRL_LINE_SCAN = 0;
    localparam int unsigned CTRL_BOTTOM_UP = 1;
    localparam int unsigned CTRL_HOLDS_BUFFERS = 2;
    localparam int unsigned CTRL_SAMPLE_RUN = 3;
    // Reset values and unmapped read value
    localparam logic [31:0] RST_LINE_PAYLOAD = 32'h0000_0400;
    localparam logic [31:0] RST_LINE_STRIDE = 32'h0000_0000;
    localparam logic [15:0] RST_GROUP_HEIGHT = 16'h0001;
    localparam logic [15:0] RST_GROUP_STRIDE = 16'h0000;
    localparam logic [31:0] RST_BUF_LENGTH = 32'h0010_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // Statistics windows
    typedef enum logic [2:0] {
        IBDW_WIN_ONE_SECOND = 3'h0,
        IBDW_WIN_TEN_SECONDS = 3'h1,
        IBDW_WIN_BUF2 = 3'h2,
        IBDW_WIN_BUF10 = 3'h3,
        IBDW_WIN_BUF100 = 3'h4,
        IBDW_WIN_BUF1000 = 3'h5,
        IBDW_WIN_ACQ_PERIOD = 3'h6
    } ibdw_win_t;
    // Timing
    localparam longint unsigned CLK_HZ = 25000000;
    localparam int unsigned ONE_SECOND_S = 1;
    localparam int unsigned TEN_SECONDS_S = 10;
    localparam longint unsigned ONE_SECOND_CYC = CLK_HZ * ONE_SECOND_S;
    localparam logic [15:0] BYTES_PER_MB = 16'h4240;
    localparam logic [31:0] MEGA = 32'h000F_4240;
    // States
    typedef enum logic [1:0] {
        IBDW_IDLE = 2'b00,
        IBDW_DATA = 2'b01,
        IBDW_SKIP = 2'b11
    } ibdw_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ibdw_reg_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic first;
        logic last_of_line;
        logic last_of_image;
    } ibdw_pix_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } ibdw_wr_t;
    typedef struct packed {
        ibdw_state_t st;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] line_payload;
        logic [31:0] line_stride;
        logic [15:0] group_height;
        logic [15:0] group_stride;
        logic [31:0] buf_start;
        logic [31:0] buf_length;
        ibdw_win_t win;
        logic [31:0] line_base;
        logic [31:0] line_off;
        logic [15:0] group_line;
        logic [31:0] lines_in_buf;
        logic drop;
        ibdw_wr_t wr;
        logic release_pulse;
        logic [31:0] buf_bytes;
        logic [31:0] buf_units;
        logic [31:0] win_cycles;
        logic [31:0] acc_buffers;
        logic [31:0] acc_units;
        logic [31:0] acc_bytes;
        logic [31:0] acc_cycles;
        logic [31:0] st_buffers;
        logic [31:0] st_units;
        logic [31:0] st_bytes;
        logic [31:0] st_cycles;
        logic [31:0] released;
        logic [31:0] rel_bytes;
    } ibdw_state_all_t;
endpackage : ibdw_pkg

/* logic/ibdw_writer.sv */
// Purpose: Image buffer DMA writer with padding, flip and statistics
// Assumes: One 32-bit word per beat, payload and strides multiples of four
// Notes: Memory writes are fire-and-forget; a new buffer is always ready
module ibdw_writer #(
    parameter longint unsigned ONE_SECOND_CYCLES = ibdw_pkg::ONE_SECOND_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire ibdw_pkg::ibdw_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Pixel stream
    input wire ibdw_pkg::ibdw_pix_t pix_in,
    // Host memory writes
    output ibdw_pkg::ibdw_wr_t mem_wr,
    // Buffer release
    output logic buf_release,
    output logic [31:0] buf_release_base,
    output logic [31:0] buf_release_bytes
);
    ibdw_pkg::ibdw_state_all_t s;
    ibdw_pkg::ibdw_state_all_t next_s;
    logic [31:0] eff_stride;
    logic [15:0] eff_height;
    logic [31:0] slots;
    logic [31:0] flip_first;
    logic line_scan;
    logic bottom_up;
    logic [31:0] win_limit;
    logic win_is_buf;
    logic [31:0] reg_map;

    // Effective placement geometry and flipped start address
    always_comb begin
        eff_stride = (s.line_stride == 32'h0) ? s.line_payload : s.line_stride;
        eff_height = (s.group_height == 16'h0) ? 16'h0001 : s.group_height;
        if (eff_stride == 32'h0) begin
            slots = 32'h0;
        end else begin
            slots = (s.buf_length + eff_stride - s.line_payload) / eff_stride;
        end
        flip_first = s.buf_start + slots * eff_stride - eff_stride;
        line_scan = s.ctrl[ibdw_pkg::CTRL_LINE_SCAN];
        bottom_up = s.ctrl[ibdw_pkg::CTRL_BOTTOM_UP];
    end

    // Window limit selection
    always_comb begin
        win_is_buf = 1'b1;
        case (s.win)
            ibdw_pkg::IBDW_WIN_BUF2: win_limit = 32'h2;
            ibdw_pkg::IBDW_WIN_BUF10: win_limit = 32'hA;
            ibdw_pkg::IBDW_WIN_BUF100: win_limit = 32'h64;
            ibdw_pkg::IBDW_WIN_BUF1000: win_limit = 32'h3E8;
            ibdw_pkg::IBDW_WIN_TEN_SECONDS: begin
                win_is_buf = 1'b0;
                win_limit = 32'(ONE_SECOND_CYCLES * ibdw_pkg::TEN_SECONDS_S);
            end
            ibdw_pkg::IBDW_WIN_ACQ_PERIOD: begin
                win_is_buf = 1'b0;
                win_limit = 32'hFFFF_FFFF;
            end
            default: begin
                win_is_buf = 1'b0;
                win_limit = 32'(ONE_SECOND_CYCLES);
            end
        endcase
    end

    // Register read map, rates divided on read
    always_comb begin
        case (reg_req.addr)
            ibdw_pkg::OFS_CTRL: reg_map = s.ctrl;
            ibdw_pkg::OFS_LINE_PAYLOAD: reg_map = s.line_payload;
            ibdw_pkg::OFS_LINE_STRIDE: reg_map = s.line_stride;
            ibdw_pkg::OFS_GROUP_HEIGHT: reg_map = {16'h0, s.group_height};
            ibdw_pkg::OFS_GROUP_STRIDE: reg_map = {16'h0, s.group_stride};
            ibdw_pkg::OFS_BUF_START: reg_map = s.buf_start;
            ibdw_pkg::OFS_BUF_LENGTH: reg_map = s.buf_length;
            ibdw_pkg::OFS_STATUS: reg_map = s.released;
            ibdw_pkg::OFS_WIN_SELECT: reg_map = {29'h0, s.win};
            ibdw_pkg::OFS_WIN_BUFFERS: reg_map = s.st_buffers;
            ibdw_pkg::OFS_WIN_UNITS: reg_map = s.st_units;
            ibdw_pkg::OFS_WIN_BYTES: reg_map = s.st_bytes;
            ibdw_pkg::OFS_WIN_CYCLES: reg_map = s.st_cycles;
            ibdw_pkg::OFS_AVG_FRAME_RATE, ibdw_pkg::OFS_AVG_LINE_RATE: begin
                reg_map = (s.st_cycles == 32'h0) ? 32'h0
                    : 32'((64'(s.st_units) * ibdw_pkg::CLK_HZ) / s.st_cycles);
            end
            ibdw_pkg::OFS_AVG_BYTE_RATE: begin
                reg_map = (s.st_cycles == 32'h0) ? 32'h0
                    : 32'((64'(s.st_bytes) * ibdw_pkg::CLK_HZ)
                    / (64'(s.st_cycles) * ibdw_pkg::MEGA));
            end
            default: reg_map = ibdw_pkg::UNMAPPED_READ;
        endcase
    end

    // Next-state logic
    always_comb begin
        logic geo_ok;
        logic start_buf;
        logic fits;
        logic [31:0] addr;
        logic [31:0] pad_lines;
        logic close;
        logic new_line_needed;
        geo_ok = 1'b0;
        start_buf = 1'b0;
        fits = 1'b0;
        addr = 32'h0;
        pad_lines = 32'h0;
        close = 1'b0;
        new_line_needed = 1'b0;
        next_s = s;
        next_s.wr.valid = 1'b0;
        next_s.release_pulse = 1'b0;
        next_s.rdata = reg_map;
        geo_ok = !s.ctrl[ibdw_pkg::CTRL_HOLDS_BUFFERS];

        // Register writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                ibdw_pkg::OFS_CTRL: next_s.ctrl = {28'h0, reg_req.wdata[3:0]};
                ibdw_pkg::OFS_LINE_PAYLOAD: begin
                    if (geo_ok) next_s.line_payload = reg_req.wdata;
                end
                ibdw_pkg::OFS_LINE_STRIDE: begin
                    if (geo_ok) next_s.line_stride = reg_req.wdata;
                end
                ibdw_pkg::OFS_GROUP_HEIGHT: begin
                    if (geo_ok) next_s.group_height = reg_req.wdata[15:0];
                end
                ibdw_pkg::OFS_GROUP_STRIDE: begin
                    if (geo_ok) next_s.group_stride = reg_req.wdata[15:0];
                end
                ibdw_pkg::OFS_BUF_START: next_s.buf_start = reg_req.wdata;
                ibdw_pkg::OFS_BUF_LENGTH: next_s.buf_length = reg_req.wdata;
                ibdw_pkg::OFS_WIN_SELECT: begin
                    next_s.win = ibdw_pkg::ibdw_win_t'(reg_req.wdata[2:0]);
                    next_s.acc_buffers = 32'h0;
                    next_s.acc_units = 32'h0;
                    next_s.acc_bytes = 32'h0;
                    next_s.acc_cycles = 32'h0;
                end
                default: ;
            endcase
        end

        // Pixel data placement
        if (pix_in.valid) begin
            start_buf = pix_in.first || (s.st == ibdw_pkg::IBDW_IDLE);
            if (start_buf) begin
                next_s.line_base = bottom_up ? flip_first : s.buf_start;
                next_s.line_off = 32'h0;
                next_s.group_line = 16'h0;
                next_s.lines_in_buf = 32'h0;
                next_s.buf_bytes = 32'h0;
                next_s.buf_units = 32'h0;
                next_s.drop = 1'b0;
                next_s.st = ibdw_pkg::IBDW_DATA;
            end else if (s.line_off == 32'h0 && line_scan) begin
                // Line-scan: does another whole line fit here?
                if (bottom_up) begin
                    new_line_needed = (s.line_base < s.buf_start)
                        || (s.line_base == 32'h0);
                end else begin
                    new_line_needed = (s.line_base + s.line_payload
                        > s.buf_start + s.buf_length);
                end
                if (new_line_needed) begin
                    close = 1'b1;
                    next_s.line_base = bottom_up ? flip_first : s.buf_start;
                    next_s.group_line = 16'h0;
                    next_s.lines_in_buf = 32'h0;
                    next_s.buf_bytes = 32'h0;
                    next_s.buf_units = 32'h0;
                end
            end
            addr = next_s.line_base + (start_buf ? 32'h0 : s.line_off);
            if (bottom_up) begin
                fits = (next_s.line_base >= s.buf_start) && !next_s.drop
                    && (slots != 32'h0);
            end else begin
                fits = (addr + 32'h4 <= s.buf_start + s.buf_length) && !next_s.drop;
            end
            if (fits) begin
                next_s.wr.valid = 1'b1;
                next_s.wr.addr = addr;
                next_s.wr.data = pix_in.data;
                next_s.buf_bytes = next_s.buf_bytes + 32'h4;
            end else begin
                next_s.drop = 1'b1;
            end
            next_s.line_off = (start_buf || close ? 32'h0 : s.line_off) + 32'h4;
            if (pix_in.last_of_line) begin
                // Advance by stride (by payload when a nonzero stride is smaller), add group padding; gaps never written
                next_s.line_off = 32'h0;
                next_s.group_line = next_s.group_line + 16'h1;
                pad_lines = 32'h1;
                if (next_s.group_line >= eff_height) begin
                    next_s.group_line = 16'h0;
                    if (s.group_stride > eff_height) begin
                        pad_lines = 32'h1 + 32'(s.group_stride - eff_height);
                    end
                end
                if (s.line_stride > s.line_payload || s.line_stride == 32'h0) begin
                    // Stride of zero packs lines; larger stride pads
                    pad_lines = pad_lines * eff_stride;
                end else begin
                    pad_lines = pad_lines * s.line_payload;
                end
                next_s.line_base = bottom_up ? next_s.line_base - pad_lines
                    : next_s.line_base + pad_lines;
                if (fits) begin
                    next_s.buf_units = next_s.buf_units + (line_scan ? 32'h1 : 32'h0);
                end
                next_s.st = ibdw_pkg::IBDW_SKIP;
            end else begin
                next_s.st = ibdw_pkg::IBDW_DATA;
            end
            if (pix_in.last_of_image) begin
                close = 1'b1;
                if (!line_scan) begin
                    next_s.buf_units = 32'h1;
                end
                next_s.st = ibdw_pkg::IBDW_IDLE;
            end
        end

        // Buffer release and statistics
        if (close) begin
            next_s.release_pulse = 1'b1;
            next_s.released = s.released + 32'h1;
            // Bytes of the buffer being closed, not of the one just opened
            next_s.rel_bytes = pix_in.last_of_image ? next_s.buf_bytes : s.buf_bytes;
            next_s.acc_buffers = next_s.acc_buffers + 32'h1;
            next_s.acc_units = next_s.acc_units
                + (pix_in.last_of_image ? next_s.buf_units : s.buf_units);
            next_s.acc_bytes = next_s.acc_bytes
                + (pix_in.last_of_image ? next_s.buf_bytes : s.buf_bytes);
        end
        next_s.acc_cycles = next_s.acc_cycles + 32'h1;
        if (s.win == ibdw_pkg::IBDW_WIN_ACQ_PERIOD) begin
            if (s.ctrl[ibdw_pkg::CTRL_SAMPLE_RUN]) begin
                next_s.st_buffers = next_s.acc_buffers;
                next_s.st_units = next_s.acc_units;
                next_s.st_bytes = next_s.acc_bytes;
                next_s.st_cycles = next_s.acc_cycles;
            end else begin
                next_s.acc_cycles = 32'h0;
                next_s.acc_buffers = 32'h0;
                next_s.acc_units = 32'h0;
                next_s.acc_bytes = 32'h0;
            end
        end else if ((win_is_buf && next_s.acc_buffers >= win_limit)
                || (!win_is_buf && next_s.acc_cycles >= win_limit)) begin
            next_s.st_buffers = next_s.acc_buffers;
            next_s.st_units = next_s.acc_units;
            next_s.st_bytes = next_s.acc_bytes;
            next_s.st_cycles = next_s.acc_cycles;
            next_s.acc_buffers = 32'h0;
            next_s.acc_units = 32'h0;
            next_s.acc_bytes = 32'h0;
            next_s.acc_cycles = 32'h0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.st <= ibdw_pkg::IBDW_IDLE;
            s.ctrl <= 32'h0;
            s.line_payload <= ibdw_pkg::RST_LINE_PAYLOAD;
            s.line_stride <= ibdw_pkg::RST_LINE_STRIDE;
            s.group_height <= ibdw_pkg::RST_GROUP_HEIGHT;
            s.group_stride <= ibdw_pkg::RST_GROUP_STRIDE;
            s.buf_length <= ibdw_pkg::RST_BUF_LENGTH;
            s.win <= ibdw_pkg::IBDW_WIN_ONE_SECOND;
        end else begin
            s <= next_s;
        end
    end

    // Output drive
    always_comb begin
        reg_rdata = s.rdata;
        mem_wr = s.wr;
        buf_release = s.release_pulse;
        buf_release_base = s.buf_start;
        buf_release_bytes = s.rel_bytes;
    end
endmodule : ibdw_writer

/* verif/ibdw_writer_asserts.sv */
// Purpose: Port assertions for the image buffer DMA writer
// Assumes: Register writes seen at the port mirror the control state
// Notes: Bound to every ibdw_writer instance
module ibdw_writer_asserts #(
    parameter longint unsigned ONE_SECOND_CYCLES = ibdw_pkg::ONE_SECOND_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire ibdw_pkg::ibdw_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    // Stream and memory
    input wire ibdw_pkg::ibdw_pix_t pix_in,
    input wire ibdw_pkg::ibdw_wr_t mem_wr,
    // Release
    input wire logic buf_release,
    input wire logic [31:0] buf_release_base,
    input wire logic [31:0] buf_release_bytes
);
    logic [31:0] ctl_q;
    logic [31:0] start_q;
    logic [31:0] len_q;
    logic [31:0] stride_q;
    // Shadow of the control, buffer start, buffer length and line stride registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= 32'h0;
            start_q <= 32'h0;
            len_q <= ibdw_pkg::RST_BUF_LENGTH;
            stride_q <= ibdw_pkg::RST_LINE_STRIDE;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ibdw_pkg::OFS_CTRL) ctl_q <= reg_req.wdata;
            if (reg_req.addr == ibdw_pkg::OFS_BUF_START) start_q <= reg_req.wdata;
            if (reg_req.addr == ibdw_pkg::OFS_BUF_LENGTH) len_q <= reg_req.wdata;
            if (reg_req.addr == ibdw_pkg::OFS_LINE_STRIDE && !ctl_q[2]) stride_q <= reg_req.wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_write_has_word: assert property (
        mem_wr.valid |-> $past(pix_in.valid) && mem_wr.data == $past(pix_in.data))
        else $error("host write without a matching pixel word");
    a_addr_word_aligned: assert property (mem_wr.valid |-> mem_wr.addr[1:0] == 2'h0)
        else $error("host write address not word aligned");
    a_first_at_start: assert property (
        pix_in.valid && pix_in.first && !ctl_q[1] |=> mem_wr.valid && mem_wr.addr == start_q)
        else $error("first word not at buffer start");
    a_release_at_end: assert property (pix_in.valid && pix_in.last_of_image |=> buf_release)
        else $error("no release after last word of image");
    a_release_bytes_whole: assert property (
        buf_release |-> buf_release_bytes != 32'h0 && buf_release_bytes[1:0] == 2'h0)
        else $error("released byte count not whole words");
    a_release_base: assert property (buf_release |-> buf_release_base == start_q)
        else $error("released buffer base not the buffer start");
    a_write_in_buffer: assert property (
        mem_wr.valid |-> mem_wr.addr >= start_q && mem_wr.addr + 32'h4 <= start_q + len_q)
        else $error("host write outside the buffer");
    a_stride_refused: assert property (
        reg_req.rd && reg_req.addr == ibdw_pkg::OFS_LINE_STRIDE |=> reg_rdata == stride_q)
        else $error("line stride readback wrong");
    a_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 8'h40
        |=> reg_rdata == ibdw_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
endmodule : ibdw_writer_asserts

bind ibdw_writer ibdw_writer_asserts #(.ONE_SECOND_CYCLES(ONE_SECOND_CYCLES)) i_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pix_in(pix_in), .mem_wr(mem_wr), .buf_release(buf_release),
    .buf_release_base(buf_release_base), .buf_release_bytes(buf_release_bytes));

/* verif/ibdw_host_mem.sv */
// Purpose: Host memory model receiving posted words and buffer releases
// Assumes: Host accepts every word at once
// Notes: Unwritten locations stay absent, so padding can be checked
module ibdw_host_mem (
    // Clock
    input wire logic sys_clk,
    // Host writes and releases
    input wire ibdw_pkg::ibdw_wr_t mem_wr,
    input wire logic buf_release,
    input wire logic [31:0] buf_release_bytes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [31:0]];
    logic [31:0] rel_q [$];
    int n_wr;
    // Store words and log released byte counts
    always @(posedge sys_clk) begin
        if (mem_wr.valid === 1'b1) begin
            mem[mem_wr.addr] = mem_wr.data;
            n_wr++;
        end
        if (buf_release === 1'b1) rel_q.push_back(buf_release_bytes);
    end
    task automatic clear();
        mem.delete();
        rel_q.delete();
        n_wr = 0;
    endtask : clear
endmodule : ibdw_host_mem

/* verif/testbench.sv */
// Purpose: Register and stream sequences for the image buffer DMA writer
// Assumes: Four-word lines of 16 bytes, buffer start 0x1000
// Notes: Geometry is changed only while no buffers are held
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic arst_n;
    ibdw_pkg::ibdw_reg_req_t reg_req;
    logic [31:0] reg_rdata;
    ibdw_pkg::ibdw_pix_t pix_in;
    ibdw_pkg::ibdw_wr_t mem_wr;
    logic buf_release;
    logic [31:0] buf_release_base;
    logic [31:0] buf_release_bytes;
    int n_fail;
    int comparisons;
    ibdw_writer #(.ONE_SECOND_CYCLES(100)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .pix_in(pix_in), .mem_wr(mem_wr),
        .buf_release(buf_release), .buf_release_base(buf_release_base),
        .buf_release_bytes(buf_release_bytes));
    ibdw_host_mem i_mem (.sys_clk(sys_clk), .mem_wr(mem_wr), .buf_release(buf_release),
        .buf_release_bytes(buf_release_bytes));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask : rd_reg
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        check(d, exp, "register read");
    endtask : chk_reg
    function automatic logic [31:0] word(input int k, input int w);
        return {8'hD0, 8'(k), 8'h00, 8'(w)};
    endfunction : word
    task automatic send(input int lines);
        for (int k = 0; k < lines; k++) begin
            for (int w = 0; w < 4; w++) begin
                @(posedge sys_clk);
                pix_in <= '{1'b1, word(k, w), k == 0 && w == 0, w == 3,
                    k == lines - 1 && w == 3};
            end
        end
        @(posedge sys_clk);
        pix_in <= '0;
        repeat (3) @(posedge sys_clk);
    endtask : send
    task automatic chk_line(input logic [31:0] a, input int k);
        for (int w = 0; w < 4; w += 3) begin
            if (i_mem.mem.exists(a + 4 * w)) check(i_mem.mem[a + 4 * w], word(k, w), "line word");
            else check(32'h0, word(k, w), "line word missing");
        end
    endtask : chk_line
    task automatic chk_absent(input logic [31:0] a);
        check(32'(i_mem.mem.exists(a)), 32'h0, "padding written");
    endtask : chk_absent
    task automatic chk_rel(input int n, input logic [31:0] last);
        check(32'(i_mem.rel_q.size()), 32'(n), "release count");
        if (n > 0) check(i_mem.rel_q[$], last, "released bytes");
        i_mem.clear();
    endtask : chk_rel
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("[FAIL] %0t run did not finish", $time);
        close_out();
    end
    initial begin
        logic [31:0] cyc;
        logic [63:0] per_s;
        arst_n = 1'b0;
        reg_req = '0;
        pix_in = '0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        chk_reg(ibdw_pkg::OFS_CTRL, 32'h0);
        chk_reg(ibdw_pkg::OFS_WIN_SELECT, 32'h0);
        chk_reg(ibdw_pkg::OFS_LINE_STRIDE, ibdw_pkg::RST_LINE_STRIDE);
        chk_reg(ibdw_pkg::OFS_GROUP_HEIGHT, {16'h0, ibdw_pkg::RST_GROUP_HEIGHT});
        chk_reg(8'h40, ibdw_pkg::UNMAPPED_READ);
        // Padded area-scan frame: stride 24, groups of 2 in 3 slots
        wr_reg(ibdw_pkg::OFS_LINE_PAYLOAD, 32'h10);
        wr_reg(ibdw_pkg::OFS_LINE_STRIDE, 32'h18);
        wr_reg(ibdw_pkg::OFS_GROUP_HEIGHT, 32'h2);
        wr_reg(ibdw_pkg::OFS_GROUP_STRIDE, 32'h3);
        wr_reg(ibdw_pkg::OFS_BUF_START, 32'h1000);
        wr_reg(ibdw_pkg::OFS_BUF_LENGTH, 32'h100);
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h4);
        wr_reg(ibdw_pkg::OFS_LINE_STRIDE, 32'h8);
        chk_reg(ibdw_pkg::OFS_LINE_STRIDE, 32'h18);
        send(3);
        chk_line(32'h1000, 0);
        chk_line(32'h1018, 1);
        chk_line(32'h1048, 2);
        chk_absent(32'h1010);
        chk_absent(32'h1030);
        chk_rel(1, 32'h30);
        // Frame larger than a 64-byte buffer, no padding
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h0);
        wr_reg(ibdw_pkg::OFS_LINE_STRIDE, 32'h0);
        wr_reg(ibdw_pkg::OFS_GROUP_STRIDE, 32'h0);
        wr_reg(ibdw_pkg::OFS_BUF_LENGTH, 32'h40);
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h4);
        send(6);
        check(32'(i_mem.n_wr), 32'h10, "words kept");
        chk_line(32'h1010, 1);
        chk_line(32'h1020, 2);
        chk_rel(1, 32'h40);
        // Bottom-up into an 84-byte buffer, zero height and stride
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h0);
        wr_reg(ibdw_pkg::OFS_GROUP_HEIGHT, 32'h0);
        wr_reg(ibdw_pkg::OFS_BUF_LENGTH, 32'h54);
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h6);
        send(2);
        chk_line(32'h1040, 0);
        chk_line(32'h1030, 1);
        chk_absent(32'h1050);
        chk_rel(1, 32'h20);
        // Line-scan, 40-byte buffer holds two lines
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h0);
        wr_reg(ibdw_pkg::OFS_GROUP_HEIGHT, 32'h1);
        wr_reg(ibdw_pkg::OFS_BUF_LENGTH, 32'h28);
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h5);
        send(3);
        check(i_mem.rel_q[0], 32'h20, "full buffer bytes");
        chk_line(32'h1010, 1);
        chk_line(32'h1000, 2);
        chk_rel(2, 32'h10);
        // Window selections, then a two-buffer window
        for (int c = 0; c < 7; c++) begin
            wr_reg(ibdw_pkg::OFS_WIN_SELECT, 32'(c));
            chk_reg(ibdw_pkg::OFS_WIN_SELECT, 32'(c));
        end
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h0);
        wr_reg(ibdw_pkg::OFS_BUF_LENGTH, 32'h100);
        wr_reg(ibdw_pkg::OFS_CTRL, 32'h4);
        wr_reg(ibdw_pkg::OFS_WIN_SELECT, 32'(ibdw_pkg::IBDW_WIN_BUF2));
        send(1);
        send(1);
        chk_reg(ibdw_pkg::OFS_WIN_BUFFERS, 32'h2);
        chk_reg(ibdw_pkg::OFS_WIN_UNITS, 32'h2);
        chk_reg(ibdw_pkg::OFS_WIN_BYTES, 32'h20);
        // Rates from the window's own cycle count
        rd_reg(ibdw_pkg::OFS_WIN_CYCLES, cyc);
        chk_reg(ibdw_pkg::OFS_AVG_FRAME_RATE, 32'((64'h2 * ibdw_pkg::CLK_HZ) / cyc));
        per_s = 64'(cyc) * ibdw_pkg::MEGA;
        chk_reg(ibdw_pkg::OFS_AVG_BYTE_RATE, 32'((64'h20 * ibdw_pkg::CLK_HZ) / per_s));
        // Time windows: one second is 100 cycles in this bench
        wr_reg(ibdw_pkg::OFS_WIN_SELECT, 32'(ibdw_pkg::IBDW_WIN_ONE_SECOND));
        repeat (120) @(posedge sys_clk);
        chk_reg(ibdw_pkg::OFS_WIN_CYCLES, 32'h64);
        wr_reg(ibdw_pkg::OFS_WIN_SELECT, 32'(ibdw_pkg::IBDW_WIN_TEN_SECONDS));
        repeat (1010) @(posedge sys_clk);
        chk_reg(ibdw_pkg::OFS_WIN_CYCLES, 32'h3E8);
        close_out();
    end
endmodule : testbench
